//--- verilog/bst_pkg.sv
/*
  Constants, instruction codes, identification field layout and TAP states
  for the boundary-scan test access port.
  Assumes the scan pins are sampled by a system clock much faster than the test clock.
*/
// How it works
// - The all-ones code puts the one-bit bypass register between data in and data out during shift-DR.
// - The all-zeros code captures the I/O ring and shifts through the boundary scan register.
// - The identification code loads the hardwired identification word and shifts it out.
// - The sample/preload code snapshots the I/O ring into the boundary scan register and shifts it.
// - The clamp code shifts through bypass while outputs take the boundary scan register values.
// - The high-impedance code shifts through bypass and floats every device output.
// - Identification bits 31:28 hold die revision (upper two) and data width organization (lower two).
// - Identification bits 27:12 hold a fixed device code for family, density and I/O style.
// - Identification bits 11:1 hold a fixed maker code.
// - Identification bit 0 always reads one.
// - The instruction register is eight bits and captures binary 01 in its two low bits in capture-IR.
// - Five rising test-clock edges with mode-select high reset the port, and reset selects identification.
// - Serial data enters the MSB on rising test-clock edges and leaves the LSB on falling edges, only in shifts.
package bst_pkg;

    localparam int IR_W  = 8;
    localparam int BSR_W = 113;
    localparam int ID_W  = 32;

    localparam logic [7:0] CODE_EXTEST  = 8'h00;
    localparam logic [7:0] CODE_IDCODE  = 8'h21;
    localparam logic [7:0] CODE_SAMPLE  = 8'h05;
    localparam logic [7:0] CODE_CLAMP   = 8'h07;
    localparam logic [7:0] CODE_HIGHZ   = 8'h03;
    localparam logic [7:0] CODE_BYPASS  = 8'hff;

    localparam logic [1:0] IR_CAPTURE_LOW  = 2'h1;
    localparam logic [5:0] IR_CAPTURE_HIGH = 6'h00;

    // Identification field positions
    localparam int ID_REV_LSB = 28;
    localparam int ID_DEV_LSB = 12;
    localparam int ID_VEN_LSB = 1;
    localparam logic ID_PRESENT = 1'b1;

    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h3,
        ST_CAPTURE_DR = 4'h2,
        ST_SHIFT_DR   = 4'h6,
        ST_EXIT1_DR   = 4'h7,
        ST_PAUSE_DR   = 4'h5,
        ST_EXIT2_DR   = 4'h4,
        ST_UPDATE_DR  = 4'hc,
        ST_SEL_IR     = 4'hd,
        ST_CAPTURE_IR = 4'hf,
        ST_SHIFT_IR   = 4'he,
        ST_EXIT1_IR   = 4'ha,
        ST_PAUSE_IR   = 4'hb,
        ST_EXIT2_IR   = 4'h9,
        ST_UPDATE_IR  = 4'h8
    } bst_state_e;

endpackage

//--- verilog/bst_tap_if.sv
/*
  Carrier between the port core and its state controller.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface bst_tap_if;
    logic                tck_rise;
    logic                tms;
    bst_pkg::bst_state_e state;

    modport core (output tck_rise, output tms, input state);
    modport fsm  (input tck_rise, input tms, output state);
endinterface

//--- verilog/bst_tap_fsm.sv
/*
  Sixteen-state test access port controller, stepped on rising test-clock edges.
  Assumes tck_rise is a one-cycle strobe and tms is already synchronised.
*/
`timescale 1ns/1ps
module bst_tap_fsm (
    input  wire logic clock,   // System clock
    input  wire logic sys_rst, // Synchronous reset, high
    bst_tap_if.fsm    tap      // Edge strobe, mode select, state
);

    bst_pkg::bst_state_e next_state;

    always_comb
    begin
        next_state = tap.state;
        case (tap.state)
            bst_pkg::ST_RESET:      next_state = tap.tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:       next_state = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:     next_state = tap.tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAPTURE_DR;
            bst_pkg::ST_CAPTURE_DR: next_state = tap.tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_SHIFT_DR:   next_state = tap.tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR:   next_state = tap.tms ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR:   next_state = tap.tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR:   next_state = tap.tms ? bst_pkg::ST_UPDATE_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPDATE_DR:  next_state = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:     next_state = tap.tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAPTURE_IR;
            bst_pkg::ST_CAPTURE_IR: next_state = tap.tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_SHIFT_IR:   next_state = tap.tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR:   next_state = tap.tms ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR:   next_state = tap.tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR:   next_state = tap.tms ? bst_pkg::ST_UPDATE_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_UPDATE_IR:  next_state = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            default:                next_state = bst_pkg::ST_RESET;
        endcase
    end

    // Five high mode-select edges reach reset from any state
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            tap.state <= bst_pkg::ST_RESET;
        else if (tap.tck_rise)
            tap.state <= next_state;
    end

endmodule

//--- verilog/bst_top.sv
/*
  Boundary-scan test access port: instruction decode, bypass, identification
  and boundary scan registers, serial output and output-pin control.
  Assumes tck, tms, tdi and the I/O ring arrive asynchronously and are
  sampled by clock, which must run several times faster than tck.
*/
`timescale 1ns/1ps
module bst_top #(
    parameter logic [1:0]  DIE_REV     = 2'h0,     // Die revision, arbitrary
    parameter logic [1:0]  ORG_CODE    = 2'h1,     // Data width organization, arbitrary
    parameter logic [15:0] DEVICE_CODE = 16'h1234, // Device code, arbitrary value
    parameter logic [10:0] VENDOR_CODE = 11'h2a5   // Maker code, arbitrary value
) (
    input  wire logic                      clock,          // System clock, 20 MHz
    input  wire logic                      sys_rst,        // Synchronous reset, high
    input  wire logic                      tck,            // Test clock pin
    input  wire logic                      tms,            // Mode select pin
    input  wire logic                      tdi,            // Serial data in pin
    input  wire logic [bst_pkg::BSR_W-1:0] ring_in,        // Levels on the I/O ring
    output logic                           tdo_o,          // Serial data out value
    output logic                           tdo_oe_n,       // Serial out enable, low drives
    output logic [bst_pkg::BSR_W-1:0]      bsr_drive,      // Values held for output pins
    output logic                           pins_from_bsr,  // Outputs take bsr_drive
    output logic                           pins_hiz        // All outputs float
);

    logic [2:0]                tck_sync;
    logic [1:0]                tms_sync;
    logic [1:0]                tdi_sync;
    logic [bst_pkg::BSR_W-1:0] ring_meta;
    logic [bst_pkg::BSR_W-1:0] ring_sync;
    logic                      tck_fall;
    logic [bst_pkg::IR_W-1:0]  ir_shift;
    logic [bst_pkg::IR_W-1:0]  ir_active;
    logic                      bypass_bit;
    logic [bst_pkg::ID_W-1:0]  id_shift;
    logic [bst_pkg::BSR_W-1:0] bsr_shift;
    logic                      sel_bsr;
    logic                      sel_id;
    logic [bst_pkg::ID_W-1:0]  id_word;

    bst_tap_if tap ();

    bst_tap_fsm u_fsm (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tap     (tap.fsm)
    );

    // Pin synchronisers; the second stage is read, and for tck the third stage too for edge detection
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tck_sync <= 3'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h3;
        end
        else
        begin
            tck_sync <= {tck_sync[1:0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
        end
    end

    always_ff @(posedge clock)
    begin
        ring_meta <= ring_in;
        ring_sync <= ring_meta;
    end

    assign tap.tck_rise = tck_sync[1] & ~tck_sync[2];
    assign tap.tms      = tms_sync[1];
    assign tck_fall     = ~tck_sync[1] & tck_sync[2];

    assign id_word = {DIE_REV, ORG_CODE,
                      DEVICE_CODE,
                      VENDOR_CODE,
                      bst_pkg::ID_PRESENT};

    // Reserved codes fall through to bypass
    assign sel_bsr = (ir_active == bst_pkg::CODE_EXTEST) || (ir_active == bst_pkg::CODE_SAMPLE);
    assign sel_id  = (ir_active == bst_pkg::CODE_IDCODE);

    // Instruction register: capture, shift and update
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ir_shift  <= {bst_pkg::IR_CAPTURE_HIGH, bst_pkg::IR_CAPTURE_LOW};
            ir_active <= bst_pkg::CODE_IDCODE;
        end
        else if (tap.tck_rise)
        begin
            case (tap.state)
                bst_pkg::ST_RESET:      ir_active <= bst_pkg::CODE_IDCODE;
                bst_pkg::ST_CAPTURE_IR: ir_shift  <= {bst_pkg::IR_CAPTURE_HIGH, bst_pkg::IR_CAPTURE_LOW};
                bst_pkg::ST_SHIFT_IR:   ir_shift  <= {tdi_sync[1], ir_shift[bst_pkg::IR_W-1:1]};
                bst_pkg::ST_UPDATE_IR:  ir_active <= ir_shift;
                default:                ir_active <= ir_active;
            endcase
        end
    end

    // Bypass register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            bypass_bit <= 1'b0;
        else if (tap.tck_rise && !sel_bsr && !sel_id)
        begin
            if (tap.state == bst_pkg::ST_CAPTURE_DR)
                bypass_bit <= 1'b0;
            else if (tap.state == bst_pkg::ST_SHIFT_DR)
                bypass_bit <= tdi_sync[1];
        end
    end

    // Identification register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            id_shift <= '0;
        else if (tap.tck_rise && sel_id)
        begin
            if (tap.state == bst_pkg::ST_CAPTURE_DR)
                id_shift <= id_word;
            else if (tap.state == bst_pkg::ST_SHIFT_DR)
                id_shift <= {tdi_sync[1], id_shift[bst_pkg::ID_W-1:1]};
        end
    end

    // Boundary scan register and its update stage
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            bsr_shift <= '0;
            bsr_drive <= '0;
        end
        else if (tap.tck_rise && sel_bsr)
        begin
            if (tap.state == bst_pkg::ST_CAPTURE_DR)
                bsr_shift <= ring_sync;
            else if (tap.state == bst_pkg::ST_SHIFT_DR)
                bsr_shift <= {tdi_sync[1], bsr_shift[bst_pkg::BSR_W-1:1]};
            else if (tap.state == bst_pkg::ST_UPDATE_DR)
                bsr_drive <= bsr_shift;
        end
    end

    // Serial output changes on falling edges, driven only in shifts
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tdo_o    <= 1'b0;
            tdo_oe_n <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_oe_n <= 1'b1;
            if (tap.state == bst_pkg::ST_SHIFT_IR)
            begin
                tdo_o    <= ir_shift[0];
                tdo_oe_n <= 1'b0;
            end
            else if (tap.state == bst_pkg::ST_SHIFT_DR)
            begin
                tdo_oe_n <= 1'b0;
                if (sel_bsr)
                    tdo_o <= bsr_shift[0];
                else if (sel_id)
                    tdo_o <= id_shift[0];
                else
                    tdo_o <= bypass_bit;
            end
        end
    end

    // Output pin control follows the active instruction
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pins_from_bsr <= 1'b0;
            pins_hiz      <= 1'b0;
        end
        else
        begin
            pins_from_bsr <= (ir_active == bst_pkg::CODE_CLAMP) || (ir_active == bst_pkg::CODE_EXTEST);
            pins_hiz      <= (ir_active == bst_pkg::CODE_HIGHZ);
        end
    end

endmodule

//--- verification/bst_monitor.sv
/*
  Checker for the boundary-scan port, bound to bst_top.
  Assumes a test-clock half period of at least four system clocks.
*/
`timescale 1ns/1ps
module bst_monitor (
    input wire logic                      clock,         // System clock
    input wire logic                      sys_rst,       // Reset, high
    input wire logic                      tck,           // Test clock
    input wire logic                      tms,           // Mode select
    input wire logic                      tdi,           // Serial in
    input wire logic [bst_pkg::BSR_W-1:0] ring_in,       // Ring levels
    input wire logic                      tdo_o,         // Serial out
    input wire logic                      tdo_oe_n,      // Out enable, low
    input wire logic [bst_pkg::BSR_W-1:0] bsr_drive,     // Update stage
    input wire logic                      pins_from_bsr, // Clamp mode
    input wire logic                      pins_hiz       // Float mode
);
    default clocking mon_clk @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_tdo_at_fall: assert property ($changed(tdo_o) |-> !$past(tck, 1) &&
        ($past(tck, 3) || $past(tck, 4) || $past(tck, 5)))
        else $error("serial out moved away from a test clock fall");
    a_oe_at_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck, 1) &&
        ($past(tck, 3) || $past(tck, 4) || $past(tck, 5)))
        else $error("out enable moved away from a test clock fall");
    a_oe_low_hold: assert property ($fell(tdo_oe_n) |-> (!tdo_oe_n) [*7])
        else $error("out enable released within one test clock period");
    a_pins_excl: assert property (!(pins_hiz && pins_from_bsr))
        else $error("float and clamp modes both active");
    a_hiz_at_rise: assert property ($changed(pins_hiz) |-> $past(tck, 2) && $past(tck, 3))
        else $error("float mode changed away from a test clock rise");
    a_clamp_at_rise: assert property ($changed(pins_from_bsr) |-> $past(tck, 2) && $past(tck, 3))
        else $error("clamp mode changed away from a test clock rise");
    a_drive_update: assert property ($changed(bsr_drive) |-> $past(tck, 2) && !pins_hiz)
        else $error("update stage loaded at a wrong moment");
    a_reset_values: assert property ($fell(sys_rst) |-> tdo_oe_n && !tdo_o &&
        !pins_hiz && !pins_from_bsr && bsr_drive == '0)
        else $error("outputs not at reset values");

    c_hiz: cover property ($rose(pins_hiz));
    c_clamp: cover property ($rose(pins_from_bsr));
    c_shift: cover property ($fell(tdo_oe_n));
endmodule

bind bst_top bst_monitor bst_monitor_inst (
    .clock(clock), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .ring_in(ring_in), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .bsr_drive(bsr_drive),
    .pins_from_bsr(pins_from_bsr), .pins_hiz(pins_hiz));

//--- verification/bst_jtag_model.sv
/*
  Test controller driving the four-wire port.
  Assumes 20 MHz clock; test clock is 400 ns and parks low between scans.
*/
`timescale 1ns/1ps
module bst_jtag_model (
    input  wire logic clock, // System clock
    input  wire logic tdo_o, // Serial out of the port
    output logic      tck,   // Test clock
    output logic      tms,   // Mode select
    output logic      tdi    // Serial in, idles high
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock: four clocks low, four high; tms and tdi steady over the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clock);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clock);
        o = tdo_o;
        tck <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    task automatic park();
        @(posedge clock);
        tck <= 1'b0;
        tdi <= 1'b1;
    endtask

    task automatic reset_walk(input int k);
        logic o;
        repeat (k) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        park();
    endtask

    // From Idle through capture and shift, then Update and back to Idle
    task automatic scan(input logic ir, input int n, input logic [112:0] din, output logic [112:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        park();
    endtask
endmodule

//--- verification/bst_top_test.sv
/*
  Self-checking bench for bst_top with a test controller model.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module bst_top_test;
    // Identification fields, arbitrary values
    localparam logic [1:0]  REV_EXP = 2'h2;
    localparam logic [1:0]  ORG_EXP = 2'h3;
    localparam logic [15:0] DEV_EXP = 16'hbeef;
    localparam logic [10:0] VEN_EXP = 11'h155;
    localparam logic [31:0] ID_EXP  = {REV_EXP, ORG_EXP, DEV_EXP, VEN_EXP, 1'b1};

    logic         clock;
    logic         sys_rst;
    logic [112:0] ring_in;
    logic         tck, tms, tdi, tdo_o, tdo_oe_n, pins_from_bsr, pins_hiz;
    logic [112:0] bsr_drive;
    int           failures;
    int           n_checks;

    bst_top #(.DIE_REV(REV_EXP), .ORG_CODE(ORG_EXP), .DEVICE_CODE(DEV_EXP), .VENDOR_CODE(VEN_EXP)) bst_top_inst (
        .clock(clock), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .ring_in(ring_in),
        .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n), .bsr_drive(bsr_drive),
        .pins_from_bsr(pins_from_bsr), .pins_hiz(pins_hiz));

    bst_jtag_model bst_jtag_model_inst (.clock(clock), .tdo_o(tdo_o), .tck(tck), .tms(tms), .tdi(tdi));

    task automatic check(input string what, input logic [112:0] seen, input logic [112:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic xscan(input logic ir, input int n, input logic [112:0] din, output logic [112:0] dout);
        bst_jtag_model_inst.scan(ir, n, din, dout);
        repeat (4) @(posedge clock);
        check("tdo enable idle", tdo_oe_n, 1'b1);
    endtask

    task automatic t_power_id();
        logic [112:0] got;
        bst_jtag_model_inst.reset_walk(0);
        // Bits past the word are the first two shifted in, so 0 then 1
        xscan(1'b0, 34, 113'h2, got);
        check("id word", got[33:0], {2'b10, ID_EXP});
    endtask

    task automatic t_codes();
        logic [7:0]   codes [7];
        logic [112:0] got, pat, ring, held;
        codes = '{bst_pkg::CODE_SAMPLE, bst_pkg::CODE_EXTEST, bst_pkg::CODE_CLAMP, bst_pkg::CODE_BYPASS,
                  8'h5a, bst_pkg::CODE_IDCODE, bst_pkg::CODE_HIGHZ};
        held = '0;
        for (int k = 0; k < 7; k++)
        begin
            ring = {1'b1, {14{codes[k] ^ 8'h3c}}};
            pat = {1'b0, {14{codes[k] ^ 8'h96}}};
            ring_in <= ring;
            xscan(1'b1, 8, {105'h0, codes[k]}, got);
            check("ir capture", got[7:0], 8'h01);
            check("pins hiz", pins_hiz, codes[k] == bst_pkg::CODE_HIGHZ);
            check("pins clamp", pins_from_bsr, (codes[k] == bst_pkg::CODE_CLAMP) ||
                  (codes[k] == bst_pkg::CODE_EXTEST));
            if (codes[k] == bst_pkg::CODE_EXTEST || codes[k] == bst_pkg::CODE_SAMPLE)
            begin
                xscan(1'b0, 113, pat, got);
                check("ring capture", got, ring);
                check("preload drive", bsr_drive, pat);
                held = pat;
            end
            else if (codes[k] == bst_pkg::CODE_IDCODE)
            begin
                xscan(1'b0, 32, pat, got);
                check("id path", got[31:0], ID_EXP);
            end
            else
            begin
                xscan(1'b0, 4, 113'hb, got);
                check("bypass path", got[3:0], 4'h6);
                check("drive held", bsr_drive, held);
            end
        end
    endtask

    task automatic t_tap_reset();
        logic [112:0] got;
        bst_jtag_model_inst.reset_walk(5);
        check("hiz after reset", pins_hiz, 1'b0);
        xscan(1'b0, 32, '0, got);
        check("id after reset", got[31:0], ID_EXP);
        // System reset in mid-run, test clock parked low
        xscan(1'b1, 8, {105'h0, bst_pkg::CODE_CLAMP}, got);
        check("clamp before reset", pins_from_bsr, 1'b1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        check("clamp after reset", pins_from_bsr, 1'b0);
        check("drive after reset", bsr_drive, '0);
        t_power_id();
    endtask

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    initial
    begin
        failures = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        ring_in = '0;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        t_power_id();
        t_codes();
        t_tap_reset();
        close_out();
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        failures++;
        close_out();
    end
endmodule
